// ==== rtl/tsm_device.sv ====
// sensor controller end: mode control, registers, tick and interrupt spacing
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module tsm_device #(
  parameter int MS_CYCLES = tsm_pkg::MS_CYCLES,
  parameter logic [7:0] PART_INFO = 8'h3c // arbitrary value
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link to host
  tsm_link_if.device link,
  // sensor side inputs
  input wire logic [7:0] queue_data_in,
  input wire logic [7:0] fault_in,
  input wire logic [7:0] wheel_in,
  input wire logic touch_event,
  // sensor side outputs
  output tsm_pkg::tsm_mode_e mode,
  output logic scan_active,
  output logic low_power,
  output logic master_tick,
  output logic scan_tick,
  output logic queue_pop,
  output logic queue_clear,
  output logic sensor_reset,
  output logic [7:0] wheel_setup,
  output logic [7:0] touch_threshold,
  output logic [7:0] tick_period,
  output logic [7:0] scan_interval,
  output logic [7:0] click_tone_setup,
  output logic [7:0] sleep_setup,
  output logic [7:0] held_touch_timeout
);
  localparam int MSW = $clog2(MS_CYCLES + 1);

  // clamp a written code to its legal range
  function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lim, input logic [7:0] fix);
    return (v > lim) ? fix : v;
  endfunction : clamp

  // mode decode from the configuration byte
  function automatic tsm_pkg::tsm_mode_e mode_of(input logic [7:0] c);
    return tsm_pkg::tsm_mode_e'({c[tsm_pkg::B_RUN], c[tsm_pkg::B_DUTYN]});
  endfunction : mode_of

  logic [7:0] cfg; // configuration byte
  logic [7:0] queue_view; // event queue as read
  logic wake_s1; // synchroniser first stage
  logic wake_s2; // synchroniser second stage
  logic wake_s3; // previous synchronised level
  logic wake_fall; // one-cycle falling edge
  logic soft_rst; // software reset pulse
  tsm_pkg::tsm_mode_e cur; // live mode
  logic answerable; // link is served
  logic take; // request accepted this cycle
  logic wr_ok; // write allowed to store
  logic [7:0] rd_val; // read mux
  logic [MSW-1:0] ms_cnt; // millisecond prescaler
  logic ms_pulse; // one pulse per ms
  logic [7:0] period_ms; // primary clock period
  logic [7:0] tick_ms; // ms within period
  logic [7:0] scan_cnt; // ticks within scan period
  logic [8:0] scan_lim9; // scan period minus one, wide
  logic [7:0] scan_lim; // scan period minus one
  logic pending; // interrupt event waiting
  logic [3:0] gap_cnt; // ticks until next interrupt

  assign cur = mode_of(cfg);
  assign answerable = (cur == tsm_pkg::awake_idle_mode) || (cur == tsm_pkg::continuous_scan_mode);
  assign take = link.req & ~link.ack & answerable;
  assign wr_ok = take & link.wr & ((cur == tsm_pkg::awake_idle_mode) || (link.addr == tsm_pkg::REG_CFG));
  assign wake_fall = wake_s3 & ~wake_s2;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_s1 <= 1'b1;
      wake_s2 <= 1'b1;
      wake_s3 <= 1'b1;
    end else begin
      wake_s1 <= link.wake_attention_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
    end
  end

  // configuration register
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      cfg <= tsm_pkg::CFG_RST;
    end else begin
      // writes cannot reach here in duty or off
      if (wr_ok && link.addr == tsm_pkg::REG_CFG) begin
        cfg <= link.wdata;
      end
      if (wake_fall) begin
        cfg[tsm_pkg::B_DUTYN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_ok && (link.addr == tsm_pkg::REG_CFG) && !link.wdata[tsm_pkg::B_SRST];
    end
  end
  assign sensor_reset = soft_rst;

  // writable setup registers
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      wheel_setup <= tsm_pkg::WHEEL_SETUP_RST;
      scan_interval <= tsm_pkg::SCAN_RST;
      tick_period <= tsm_pkg::TICK_RST;
      touch_threshold <= tsm_pkg::ZERO_RST;
      click_tone_setup <= tsm_pkg::TONE_RST;
      sleep_setup <= tsm_pkg::ZERO_RST;
      held_touch_timeout <= tsm_pkg::ZERO_RST;
    end else if (wr_ok) begin
      case (link.addr)
        tsm_pkg::REG_WHEEL_SETUP: begin
          wheel_setup <= link.wdata;
        end
        tsm_pkg::REG_THRESH: begin
          touch_threshold <= link.wdata;
        end
        tsm_pkg::REG_TICK: begin
          tick_period <= clamp(link.wdata, tsm_pkg::TICK_MAX, tsm_pkg::TICK_FIX);
        end
        tsm_pkg::REG_SCAN: begin
          scan_interval <= clamp(link.wdata, tsm_pkg::SCAN_MAX, tsm_pkg::SCAN_FIX);
        end
        tsm_pkg::REG_TONE: begin
          click_tone_setup <= link.wdata;
        end
        tsm_pkg::REG_SLEEP: begin
          sleep_setup <= link.wdata;
        end
        tsm_pkg::REG_HELD: begin
          held_touch_timeout <= link.wdata;
        end
        default: begin
          // read-only or unmapped: dropped
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      queue_view <= tsm_pkg::QUEUE_RST;
    end else begin
      queue_view <= queue_data_in;
    end
  end

  // read mux
  always_comb begin
    case (link.addr)
      tsm_pkg::REG_QUEUE: rd_val = queue_view;
      tsm_pkg::REG_FAULT: rd_val = fault_in;
      tsm_pkg::REG_WHEEL_STAT: rd_val = wheel_in;
      tsm_pkg::REG_WHEEL_SETUP: rd_val = wheel_setup;
      tsm_pkg::REG_THRESH: rd_val = touch_threshold;
      tsm_pkg::REG_TICK: rd_val = tick_period;
      tsm_pkg::REG_SCAN: rd_val = scan_interval;
      tsm_pkg::REG_TONE: rd_val = click_tone_setup;
      tsm_pkg::REG_SLEEP: rd_val = sleep_setup;
      tsm_pkg::REG_HELD: rd_val = held_touch_timeout;
      tsm_pkg::REG_CFG: rd_val = cfg;
      tsm_pkg::REG_INFO: rd_val = PART_INFO;
      default: rd_val = tsm_pkg::ZERO_RST;
    endcase
  end

  // link answer and queue strobes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link.ack <= 1'b0;
      link.rdata <= tsm_pkg::ZERO_RST;
      queue_pop <= 1'b0;
      queue_clear <= 1'b0;
    end else begin
      // answer one cycle after the request
      link.ack <= take;
      if (take) begin
        link.rdata <= rd_val;
      end
      queue_pop <= take && !link.wr && (link.addr == tsm_pkg::REG_QUEUE);
      queue_clear <= wr_ok && (link.addr == tsm_pkg::REG_QUEUE);
    end
  end

  assign period_ms = (cur == tsm_pkg::continuous_scan_mode) ? tick_period + tsm_pkg::TICK_OFFSET_MS
                                                            : tsm_pkg::FIXED_PERIOD_MS;

  // millisecond prescaler, halted when off
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst || cur == tsm_pkg::powered_off_mode) begin
      ms_cnt <= '0;
      ms_pulse <= 1'b0;
    end else if (ms_cnt == MSW'(MS_CYCLES - 1)) begin
      ms_cnt <= '0;
      ms_pulse <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + MSW'(1);
      ms_pulse <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || soft_rst || cur == tsm_pkg::powered_off_mode) begin
      tick_ms <= '0;
      master_tick <= 1'b0;
    end else if (ms_pulse && tick_ms >= period_ms - 8'h01) begin
      tick_ms <= '0;
      master_tick <= 1'b1;
    end else begin
      tick_ms <= ms_pulse ? tick_ms + 8'h01 : tick_ms;
      master_tick <= 1'b0;
    end
  end

  assign scan_lim9 = (cur == tsm_pkg::duty_cycled_scan_mode)
                     ? ({1'b0, scan_interval} + 9'h001) * 9'(tsm_pkg::DUTY_STRETCH) - 9'h001
                     : {1'b0, scan_interval};
  assign scan_lim = scan_lim9[7:0];

  // scanning only with run bit set
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst || !cfg[tsm_pkg::B_RUN]) begin
      scan_cnt <= '0;
      scan_tick <= 1'b0;
    end else if (master_tick && scan_cnt >= scan_lim) begin
      scan_cnt <= '0;
      scan_tick <= 1'b1;
    end else begin
      scan_cnt <= master_tick ? scan_cnt + 8'h01 : scan_cnt;
      scan_tick <= 1'b0;
    end
  end

  // mode status outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode <= tsm_pkg::awake_idle_mode;
      scan_active <= 1'b0;
      low_power <= 1'b0;
    end else begin
      mode <= cur;
      scan_active <= cfg[tsm_pkg::B_RUN];
      // duty bit low enables duty cycling
      low_power <= (cur == tsm_pkg::duty_cycled_scan_mode) && !scan_tick;
    end
  end

  // interrupt spacing and line
  always_ff @(posedge core_clk) begin
    if (srst || soft_rst) begin
      pending <= 1'b0;
      gap_cnt <= '0;
      link.irq_n <= 1'b1;
    end else begin
      // new event wins over the fire clear
      // cleared only when the line really fires, so a pop cannot eat it
      pending <= touch_event
                 | (pending & ~(link.irq_n & (gap_cnt == 4'h0) & cfg[tsm_pkg::B_IRQ_OUT] & ~queue_pop));
      if (!cfg[tsm_pkg::B_IRQ_OUT] || queue_pop) begin
        link.irq_n <= 1'b1;
      end else if (pending && link.irq_n && gap_cnt == 4'h0) begin
        link.irq_n <= 1'b0;
        // gap of code plus one ticks
        gap_cnt <= {1'b0, cfg[tsm_pkg::B_SPACE +: 3]} + 4'h1;
      end
      if (master_tick && gap_cnt != 4'h0 && link.irq_n) begin
        gap_cnt <= gap_cnt - 4'h1;
      end
    end
  end
endmodule : tsm_device

// ==== rtl/tsm_pkg.sv ====
// shared constants and types for the touch sensor mode controller
package tsm_pkg;
  // register offsets on the serial link
  localparam logic [3:0] REG_QUEUE = 4'h0;
  localparam logic [3:0] REG_FAULT = 4'h1;
  localparam logic [3:0] REG_WHEEL_STAT = 4'h2;
  localparam logic [3:0] REG_WHEEL_SETUP = 4'h3;
  localparam logic [3:0] REG_THRESH = 4'h4;
  localparam logic [3:0] REG_TICK = 4'h5;
  localparam logic [3:0] REG_SCAN = 4'h6;
  localparam logic [3:0] REG_TONE = 4'h7;
  localparam logic [3:0] REG_SLEEP = 4'h8;
  localparam logic [3:0] REG_HELD = 4'h9;
  localparam logic [3:0] REG_CFG = 4'ha;
  localparam logic [3:0] REG_INFO = 4'hb;
  // values after power-up
  localparam logic [7:0] QUEUE_RST = 8'h40;
  localparam logic [7:0] WHEEL_SETUP_RST = 8'h81;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [7:0] TICK_RST = 8'h05;
  localparam logic [7:0] SCAN_RST = 8'h01;
  localparam logic [7:0] TONE_RST = 8'h01;
  localparam logic [7:0] CFG_RST = 8'h14;
  // configuration field positions
  localparam int B_RUN = 0;
  localparam int B_IRQ_OUT = 1;
  localparam int B_DUTYN = 2;
  localparam int B_SRST = 4;
  localparam int B_SPACE = 5;
  // range limits and replacement codes
  localparam logic [7:0] TICK_MAX = 8'h1a;
  localparam logic [7:0] TICK_FIX = 8'h1a;
  localparam logic [7:0] SCAN_MAX = 8'h1f;
  localparam logic [7:0] SCAN_FIX = 8'h1f;
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int BASE_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * BASE_MS;
  localparam logic [7:0] TICK_OFFSET_MS = 8'h05;
  localparam logic [7:0] FIXED_PERIOD_MS = 8'h08;
  localparam int DUTY_STRETCH = 8;
  localparam int WAKE_LOW_NS = 250;
  localparam int WAKE_LOW_CYC = (WAKE_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int WAKE_WAIT_CYC = 8;
  localparam int LINK_TIMEOUT_CYC = 64;
  // host register offsets on apb
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_STAT = 8'h04;
  localparam logic [7:0] HREG_WAKE = 8'h08;
  // operating modes, encoded as {run, duty_n}
  typedef enum logic [1:0] {
    powered_off_mode, awake_idle_mode, duty_cycled_scan_mode, continuous_scan_mode
  } tsm_mode_e;
  // host sequencer states
  typedef enum logic [2:0] {h_idle, h_wake_low, h_wake_wait, h_req} tsm_host_e;
endpackage : tsm_pkg

// ==== rtl/tsm_link_if.sv ====
// register link and pins between host and sensor controller
`timescale 1ns/1ps
interface tsm_link_if;
  logic req; // request held until ack or timeout
  logic wr; // 1 write, 0 read
  logic [3:0] addr; // register offset
  logic [7:0] wdata; // write byte
  logic ack; // one-cycle answer
  logic [7:0] rdata; // read byte, valid with ack
  logic wake_attention_pin; // wake pin, idle high
  logic irq_n; // interrupt, active low
  modport device(input req, input wr, input addr, input wdata, input wake_attention_pin,
                 output ack, output rdata, output irq_n);
  modport host(output req, output wr, output addr, output wdata, output wake_attention_pin,
               input ack, input rdata, input irq_n);
endinterface : tsm_link_if

// ==== rtl/tsm_host.sv ====
// host end: apb command registers driving the register link
`timescale 1ns/1ps
module tsm_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to sensor controller
  tsm_link_if.host link
);
  tsm_pkg::tsm_host_e state; // sequencer state
  logic [7:0] cnt; // attention and timeout counter
  logic need_xfer; // transfer follows the wake pulse
  logic run_sh; // shadow of run bit
  logic dutyn_sh; // shadow of duty bit
  logic done; // sticky: transfer answered
  logic tmo; // sticky: no answer
  logic refused; // sticky: write refused in run mode
  logic [7:0] rd_byte; // last read byte
  logic acc; // apb access completes
  logic go; // start a transfer
  logic wake; // start a wake pulse
  logic clr_done; // status clears
  logic clr_tmo;
  logic clr_ref;
  logic bad_wr; // write that run mode would drop

  assign acc = psel & penable & pready & ~pslverr;
  assign go = acc & pwrite & (paddr == tsm_pkg::HREG_CMD) & pwdata[0] & (state == tsm_pkg::h_idle);
  assign wake = acc & pwrite & (paddr == tsm_pkg::HREG_WAKE) & (state == tsm_pkg::h_idle);
  assign clr_done = acc & pwrite & (paddr == tsm_pkg::HREG_STAT) & pwdata[1];
  assign clr_tmo = acc & pwrite & (paddr == tsm_pkg::HREG_STAT) & pwdata[2];
  assign clr_ref = acc & pwrite & (paddr == tsm_pkg::HREG_STAT) & pwdata[3];
  // only configuration may be written in run
  assign bad_wr = pwdata[1] & run_sh & (pwdata[11:8] != tsm_pkg::REG_CFG);

  // apb answer, one wait cycle, registered data
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        pslverr <= (paddr != tsm_pkg::HREG_CMD) && (paddr != tsm_pkg::HREG_STAT) && (paddr != tsm_pkg::HREG_WAKE);
        prdata <= (paddr == tsm_pkg::HREG_STAT)
                  ? {16'h0000, rd_byte, 2'b00, dutyn_sh, link.irq_n, refused, tmo, done, state != tsm_pkg::h_idle}
                  : 32'h0000_0000;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done <= 1'b0;
      tmo <= 1'b0;
      refused <= 1'b0;
    end else begin
      done <= (state == tsm_pkg::h_req && link.ack) | (done & ~clr_done);
      tmo <= (state == tsm_pkg::h_req && !link.ack && cnt == 8'h00) | (tmo & ~clr_tmo);
      refused <= (go & bad_wr) | (refused & ~clr_ref);
    end
  end

  // link sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= tsm_pkg::h_idle;
      cnt <= '0;
      need_xfer <= 1'b0;
      link.req <= 1'b0;
      link.wr <= 1'b0;
      link.addr <= '0;
      link.wdata <= '0;
      link.wake_attention_pin <= 1'b1;
      rd_byte <= '0;
      run_sh <= tsm_pkg::CFG_RST[tsm_pkg::B_RUN];
      dutyn_sh <= tsm_pkg::CFG_RST[tsm_pkg::B_DUTYN];
    end else begin
      case (state)
        tsm_pkg::h_idle: begin
          if (go && !bad_wr) begin
            link.wr <= pwdata[1];
            link.addr <= pwdata[11:8];
            link.wdata <= pwdata[23:16];
            need_xfer <= 1'b1;
            if (!dutyn_sh) begin
              link.wake_attention_pin <= 1'b0;
              cnt <= 8'(tsm_pkg::WAKE_LOW_CYC - 1);
              state <= tsm_pkg::h_wake_low;
            end else begin
              link.req <= 1'b1;
              cnt <= 8'(tsm_pkg::LINK_TIMEOUT_CYC - 1);
              state <= tsm_pkg::h_req;
            end
          end else if (wake) begin
            need_xfer <= 1'b0;
            link.wake_attention_pin <= 1'b0;
            cnt <= 8'(tsm_pkg::WAKE_LOW_CYC - 1);
            state <= tsm_pkg::h_wake_low;
          end
        end
        tsm_pkg::h_wake_low: begin
          if (cnt == 8'h00) begin
            link.wake_attention_pin <= 1'b1;
            cnt <= 8'(tsm_pkg::WAKE_WAIT_CYC - 1);
            state <= tsm_pkg::h_wake_wait;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        tsm_pkg::h_wake_wait: begin
          if (cnt == 8'h00) begin
            // device now has duty cycling off
            dutyn_sh <= 1'b1;
            link.req <= need_xfer;
            cnt <= 8'(tsm_pkg::LINK_TIMEOUT_CYC - 1);
            state <= need_xfer ? tsm_pkg::h_req : tsm_pkg::h_idle;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        tsm_pkg::h_req: begin
          if (link.ack) begin
            link.req <= 1'b0;
            state <= tsm_pkg::h_idle;
            if (!link.wr) begin
              rd_byte <= link.rdata;
            end else if (link.addr == tsm_pkg::REG_CFG) begin
              run_sh <= link.wdata[tsm_pkg::B_SRST] ? link.wdata[tsm_pkg::B_RUN] : tsm_pkg::CFG_RST[tsm_pkg::B_RUN];
              dutyn_sh <= link.wdata[tsm_pkg::B_SRST] ? link.wdata[tsm_pkg::B_DUTYN]
                                                      : tsm_pkg::CFG_RST[tsm_pkg::B_DUTYN];
            end
          end else if (cnt == 8'h00) begin
            link.req <= 1'b0;
            state <= tsm_pkg::h_idle;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          state <= tsm_pkg::h_idle;
        end
      endcase
    end
  end
endmodule : tsm_host

// ==== bench/tsm_link_sva.sv ====
// link checker watching both ends of the mode controller link
`timescale 1ns/1ps
module tsm_link_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic wake_attention_pin,
  input wire logic irq_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic rd_cfg; // last request was a config read
  logic woke; // attention fell since duty was enabled
  // remember what the last request asked for
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_cfg <= 1'b0;
    end else if (req) begin
      rd_cfg <= !wr && addr == tsm_pkg::REG_CFG;
    end
  end
  // wake seen, forgotten when duty is enabled again
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // config comes up with duty cycling off
      woke <= 1'b1;
    end else if ($fell(wake_attention_pin)) begin
      woke <= 1'b1;
    end else if (req && wr && addr == tsm_pkg::REG_CFG && !wdata[tsm_pkg::B_DUTYN] && wdata[tsm_pkg::B_SRST]) begin
      woke <= 1'b0;
    end
  end
  // wake pulse low phase and the request fields held
  sequence s_wake_low;
    !wake_attention_pin[*8];
  endsequence
  sequence s_held;
    $stable(addr) && $stable(wr) && $stable(wdata);
  endsequence
  AST_IRQ_IDLE_RESET: assert property ($past(srst) |-> irq_n)
    else $error("interrupt line not idle after reset");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req) && !$past(ack))
    else $error("answer without a request");
  AST_REQ_DROP: assert property (ack |=> !req)
    else $error("request still up after answer");
  AST_ANSWER_BOUND: assert property ($rose(req) |-> ##[1:70] !req)
    else $error("request never closed");
  AST_WAKE_LOW_HOLD: assert property ($fell(wake_attention_pin) |=> s_wake_low)
    else $error("wake pulse too short");
  AST_WAKE_GAP: assert property ($rose(wake_attention_pin) |-> !req[*7])
    else $error("request too soon after wake pulse");
  AST_REQ_HELD: assert property (req && !ack ##1 req |-> s_held)
    else $error("request fields moved while pending");
  AST_WAKE_SETS_DUTY: assert property (ack && rd_cfg && woke |-> rdata[tsm_pkg::B_DUTYN])
    else $error("wake did not disable duty cycling");
  AST_DUTY_SILENT: assert property (ack |-> woke || $past(wr && addr == tsm_pkg::REG_CFG))
    else $error("answer while duty cycling without a wake");
endmodule : tsm_link_sva

// ==== bench/touch_sensor_mode_control_tb.sv ====
// self-checking bench joining host and sensor controller over the link
`timescale 1ns/1ps
module touch_sensor_mode_control_tb;
  // clock, reset and apb master
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // sensor side stimulus and taps
  logic touch = 1'b0;
  logic mtick;
  logic scan_on; // scanning tap
  logic lp; // low power tap
  tsm_pkg::tsm_mode_e mode;
  logic [31:0] s; // last apb read word
  logic err; // last apb error flag
  int mismatches = 0;
  int tests_run = 0;
  // rows of {write, offset, data, expected read}
  logic [20:0] rows [18] = '{21'h000040, 21'h010000, 21'h020000, 21'h030081, 21'h040000, 21'h050005,
    21'h060001, 21'h070001, 21'h080000, 21'h090000, 21'h0a0014, 21'h150000, 21'h151b1a, 21'h151a1a,
    21'h16201f, 21'h145a5a, 21'h123300, 21'h197777};
  tsm_link_if lk ();
  tsm_host i_tsm_host (.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .link(lk.host));
  tsm_device #(.MS_CYCLES(4)) i_tsm_device (.core_clk, .srst, .link(lk.device), .queue_data_in(8'h40),
    .fault_in(8'h00), .wheel_in(8'h00), .touch_event(touch), .mode, .scan_active(scan_on), .low_power(lp),
    .master_tick(mtick), .scan_tick(), .queue_pop(), .queue_clear(), .sensor_reset(), .wheel_setup(),
    .touch_threshold(), .tick_period(), .scan_interval(), .click_tone_setup(), .sleep_setup(),
    .held_touch_timeout());
  tsm_link_sva i_tsm_link_sva (.core_clk, .srst, .req(lk.req), .wr(lk.wr), .addr(lk.addr),
    .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata), .wake_attention_pin(lk.wake_attention_pin),
    .irq_n(lk.irq_n));
  // 25 ns clock
  initial forever #12.5 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      wrap_up();
    end
    s = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one link transfer through the host, status left in s
  task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, 8'h04, 32'he);
    apb(1'b1, 8'h00, {8'h00, d, 4'h0, a, 6'h00, w, 1'b1});
    do begin
      apb(1'b0, 8'h04, 32'h0);
      n++;
    end while (s[0] !== 1'b0 && n < 60);
    if (s[0] !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask : op
  // master tick spacing in clock cycles
  task automatic per(input int exp);
    int n;
    n = 0;
    repeat (2) begin
      do begin
        @(posedge core_clk);
        n++;
      end while (mtick !== 1'b1 && n < 600);
    end
    if (mtick !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (mtick !== 1'b1 && n < 300);
    if (mtick !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    chk(32'(n), 32'(exp));
  endtask : per
  // one touch event, then let the line settle
  task automatic poke;
    @(posedge core_clk);
    touch <= 1'b1;
    @(posedge core_clk);
    touch <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : poke
  // counts and verdict
  task automatic wrap_up;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      op(rows[i][20], rows[i][19:16], rows[i][15:8]);
      if (rows[i][20]) op(1'b0, rows[i][19:16], 8'h00);
      chk(32'(s[15:8]), 32'(rows[i][7:0]));
    end
    apb(1'b0, 8'h0c, 32'h0);
    chk(32'(err), 32'h1); // unmapped apb word flagged
    per(32);
    op(1'b1, 4'ha, 8'h17);
    chk(32'(mode), 32'(tsm_pkg::continuous_scan_mode));
    chk(32'(scan_on), 32'h1);
    per(124);
    op(1'b1, 4'h5, 8'h09);
    chk(32'(s[3]), 32'h1);
    op(1'b0, 4'h5, 8'h00);
    chk(32'(s[15:8]), 32'h1a);
    poke();
    chk(32'(lk.irq_n), 32'h0);
    op(1'b0, 4'h0, 8'h00);
    chk(32'(lk.irq_n), 32'h1);
    op(1'b1, 4'ha, 8'h13);
    chk(32'(mode), 32'(tsm_pkg::duty_cycled_scan_mode));
    chk(32'(lp), 32'h1);
    op(1'b0, 4'ha, 8'h00);
    chk(32'(s[15:8]), 32'h17);
    op(1'b1, 4'ha, 8'h10);
    chk(32'(mode), 32'(tsm_pkg::powered_off_mode));
    chk(32'(scan_on), 32'h0);
    op(1'b0, 4'ha, 8'h00);
    chk(32'(s[15:8]), 32'h14);
    op(1'b1, 4'h5, 8'h07);
    op(1'b1, 4'ha, 8'h04);
    op(1'b0, 4'h5, 8'h00);
    chk(32'(s[15:8]), 32'h05);
    op(1'b1, 4'ha, 8'h17);
    poke();
    srst <= 1'b1;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(32'(lk.irq_n), 32'h1);
    chk(32'(mode), 32'(tsm_pkg::awake_idle_mode));
    wrap_up();
  end
endmodule : touch_sensor_mode_control_tb
